// ### rtl/ssp_pkg.sv
/*
  Constants shared by the synchronous serial port pin logic.
  Assumes a 125 MHz system clock and a slower link bit clock.
*/
package ssp_pkg;
  localparam int WORD_BITS = 16;
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic CTRL_RESET = 1'b0;
  // master clock out divided by two; one toggle per system clock
  localparam logic [0:0] TXCLK_DIV_RESET = 1'h0;

  typedef enum logic [0:0] {
    SSP_IDLE = 1'b0,
    SSP_SHIFT = 1'b1
  } ssp_state_e;
endpackage

// ### rtl/ssp_sync_if.sv
/*
  Word handshake carrier between user side and link side shifters.
  Assumes toggle based crossing; the toggles are the only event signals.
*/
`timescale 1ns/10ps
`default_nettype none
interface ssp_sync_if;
  logic [15:0] txWord;
  logic txLoadTgl;
  logic [15:0] rxWord;
  logic rxDoneTgl;
  logic txDoneTgl;
  modport core (output txWord, output txLoadTgl, input rxWord, input rxDoneTgl, input txDoneTgl);
  modport link (input txWord, input txLoadTgl, output rxWord, output rxDoneTgl, output txDoneTgl);
endinterface
`default_nettype wire

// ### rtl/ssp_link.sv
/*
  Link-side shifters on the bit clock domain.
  Assumes bitClk is the selected transmit/receive bit clock, and the
  frame pulses arrive as levels already on that clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_link (
  input wire logic bitClk,
  input wire logic rstn,
  input wire logic txFrame,
  input wire logic rxFrame,
  input wire logic serialIn,
  output logic serialOut,
  ssp_sync_if.link sif
);
  // ----------------------------------------
  // transmit shifter
  // ----------------------------------------
  logic [15:0] txShifter_q;
  logic [4:0] txCnt_q;
  logic txFramePrev_q;
  logic txLoadSeen_q;
  logic txDone_q;
  ssp_pkg::ssp_state_e txState_q;

  always_ff @(posedge bitClk or negedge rstn) begin
    if (!rstn) begin
      txFramePrev_q <= 1'b1;
      txState_q <= ssp_pkg::SSP_IDLE;
      txCnt_q <= ssp_pkg::BIT_CNT_RESET;
      txShifter_q <= ssp_pkg::WORD_RESET;
      txLoadSeen_q <= 1'b0;
      txDone_q <= 1'b0;
      serialOut <= 1'b0;
    end else begin
      txFramePrev_q <= txFrame;
      case (txState_q)
        ssp_pkg::SSP_IDLE: begin
          if (txFramePrev_q && !txFrame) begin
            txShifter_q <= {sif.txWord[14:0], 1'b0};
            serialOut <= sif.txWord[15];
            txLoadSeen_q <= sif.txLoadTgl;
            txCnt_q <= 5'h01;
            txState_q <= ssp_pkg::SSP_SHIFT;
          end
        end
        ssp_pkg::SSP_SHIFT: begin
          if (txCnt_q == 5'(ssp_pkg::WORD_BITS)) begin
            txState_q <= ssp_pkg::SSP_IDLE;
            txDone_q <= ~txDone_q;
          end else begin
            serialOut <= txShifter_q[15];
            txShifter_q <= {txShifter_q[14:0], 1'b0};
            txCnt_q <= txCnt_q + 5'h01;
          end
        end
        default: txState_q <= ssp_pkg::SSP_IDLE;
      endcase
    end
  end
  assign sif.txDoneTgl = txDone_q;

  // ----------------------------------------
  // receive shifter
  // ----------------------------------------
  logic [15:0] rxShifter_q;
  logic [15:0] rxWord_q;
  logic [4:0] rxCnt_q;
  logic rxFramePrev_q;
  logic rxDone_q;
  ssp_pkg::ssp_state_e rxState_q;

  always_ff @(posedge bitClk or negedge rstn) begin
    if (!rstn) begin
      rxFramePrev_q <= 1'b1;
      rxState_q <= ssp_pkg::SSP_IDLE;
      rxCnt_q <= ssp_pkg::BIT_CNT_RESET;
      rxShifter_q <= ssp_pkg::WORD_RESET;
      rxWord_q <= ssp_pkg::WORD_RESET;
      rxDone_q <= 1'b0;
    end else begin
      rxFramePrev_q <= rxFrame;
      case (rxState_q)
        ssp_pkg::SSP_IDLE: begin
          if (rxFramePrev_q && !rxFrame) begin
            rxShifter_q <= {15'h0000, serialIn};
            rxCnt_q <= 5'h01;
            rxState_q <= ssp_pkg::SSP_SHIFT;
          end
        end
        ssp_pkg::SSP_SHIFT: begin
          if (rxCnt_q == 5'(ssp_pkg::WORD_BITS)) begin
            rxWord_q <= rxShifter_q;
            rxDone_q <= ~rxDone_q;
            rxState_q <= ssp_pkg::SSP_IDLE;
          end else begin
            rxShifter_q <= {rxShifter_q[14:0], serialIn};
            rxCnt_q <= rxCnt_q + 5'h01;
          end
        end
        default: rxState_q <= ssp_pkg::SSP_IDLE;
      endcase
    end
  end
  assign sif.rxWord = rxWord_q;
  assign sif.rxDoneTgl = rxDone_q;
endmodule
`default_nettype wire

// ### rtl/ssp_port.sv
/*
  Pin level synchronous serial port: bit clock source, frame direction,
  float control and word exchange with the processor side.
  Assumes the partner supplies the receive clock for every transfer.
*/
// Behaviour
// - select bit 0: transmit bit clock pin is an input from partner.
// - select bit 1: device drives transmit bit clock at half master clock.
// - after reset transmit bit clock pin is an input.
// - transmit shifter drives serial output on the external link clock, also when select bit 1 drives the internal one.
// - serial input shifts into receive shifter on receive bit clock.
// - when the port is disabled, software sees receive clock pin level as a flag.
// - falling transmit frame pulse starts a transmit transfer.
// - transmit frame pulse is input after reset, output when direction bit set.
// - falling receive frame pulse starts a receive transfer.
// - float low tri-states data, frame pins; also bit clock when port unused.
`timescale 1ns/10ps
`default_nettype none
module ssp_port (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic clockSourceSelect,
  input wire logic txFrameDirection,
  input wire logic portEnable,
  input wire logic floatN,
  input wire logic [15:0] txData,
  input wire logic txLoad,
  input wire logic txFrameStart,
  output logic [15:0] rxData,
  output logic rxValid,
  output logic txDone,
  output logic rxClockLevelFlag,
  input wire logic txBitClockIn,
  output logic txBitClockOut,
  output logic txBitClockOe,
  input wire logic rxBitClock,
  input wire logic txFramePulseIn,
  output logic txFramePulseOut,
  output logic txFramePulseOe,
  input wire logic rxFramePulse,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe
);
  ssp_sync_if sif ();

  // ----------------------------------------
  // control capture and pin enables
  // ----------------------------------------
  logic clkSel_q;
  logic fsDir_q;
  logic floatN1_q;
  logic floatN_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkSel_q <= ssp_pkg::CTRL_RESET;
      fsDir_q <= ssp_pkg::CTRL_RESET;
      floatN1_q <= 1'b1;
      floatN_q <= 1'b1;
    end else begin
      clkSel_q <= clockSourceSelect;
      fsDir_q <= txFrameDirection;
      floatN1_q <= floatN;
      floatN_q <= floatN1_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txBitClockOe <= 1'b0;
      txFramePulseOe <= 1'b0;
      serialOutOe <= 1'b0;
    end else begin
      // clock driven only when selected; unused port with float floats it too
      // enables follow the captured selects so pin and divider turn on together
      // only the second float stage is read; the first may still be settling
      txBitClockOe <= clkSel_q && !(floatN_q == 1'b0 && !portEnable);
      txFramePulseOe <= fsDir_q && floatN_q;
      serialOutOe <= floatN_q;
    end
  end

  // ----------------------------------------
  // internal bit clock: half the master clock
  // ----------------------------------------
  logic txClkDiv_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txClkDiv_q <= ssp_pkg::TXCLK_DIV_RESET;
    end else begin
      txClkDiv_q <= ~txClkDiv_q;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txBitClockOut <= 1'b0;
    end else begin
      txBitClockOut <= clkSel_q ? txClkDiv_q : 1'b0;
    end
  end

  // ----------------------------------------
  // rx clock level flag
  // ----------------------------------------
  logic rxClk1_q;
  logic rxClk2_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxClk1_q <= 1'b0;
      rxClk2_q <= 1'b0;
      rxClockLevelFlag <= 1'b0;
    end else begin
      rxClk1_q <= rxBitClock;
      rxClk2_q <= rxClk1_q;
      if (!portEnable) begin
        rxClockLevelFlag <= rxClk2_q;
      end
    end
  end

  // ----------------------------------------
  // word handshake toward the link
  // ----------------------------------------
  logic [15:0] txWord_q;
  logic txLoadTgl_q;
  logic txFrameOut_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txWord_q <= ssp_pkg::WORD_RESET;
      txLoadTgl_q <= 1'b0;
      txFrameOut_q <= 1'b1;
    end else begin
      if (txLoad) begin
        txWord_q <= txData;
        txLoadTgl_q <= ~txLoadTgl_q;
      end
      // frame held low until the link reports the word sent; a short pulse
      // could fall between two edges of the slower bit clock and be missed
      if (txFrameStart) begin
        txFrameOut_q <= 1'b0;
      end else if (txDone) begin
        txFrameOut_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      txFramePulseOut <= 1'b1;
    end else begin
      txFramePulseOut <= txFrameOut_q;
    end
  end
  assign sif.txWord = txWord_q;
  assign sif.txLoadTgl = txLoadTgl_q;

  // link clock is the external bit clock; assumed same pin for both
  // directions so one domain serves transmit and receive
  // ----------------------------------------
  // internal frame into the link clock domain
  // ----------------------------------------
  // direction only changes while the link is idle, so it is used as is
  logic frameSync1_q;
  logic frameSync2_q;
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      frameSync1_q <= 1'b1;
      frameSync2_q <= 1'b1;
    end else begin
      frameSync1_q <= txFrameOut_q;
      frameSync2_q <= frameSync1_q;
    end
  end

  logic txFrameSel;
  assign txFrameSel = fsDir_q ? frameSync2_q : txFramePulseIn;

  logic linkSerialOut;
  ssp_link u_link (
    .bitClk(linkClk),
    .rstn(rstn),
    .txFrame(txFrameSel),
    .rxFrame(rxFramePulse),
    .serialIn(serialIn),
    .serialOut(linkSerialOut),
    .sif(sif.link)
  );
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      serialOut <= 1'b0;
    end else begin
      serialOut <= linkSerialOut;
    end
  end

  // ----------------------------------------
  // completion events back into sys_clk
  // ----------------------------------------
  logic [2:0] rxTgl_q;
  logic [2:0] txTgl_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxTgl_q <= 3'h0;
      txTgl_q <= 3'h0;
      rxValid <= 1'b0;
      txDone <= 1'b0;
      rxData <= ssp_pkg::WORD_RESET;
    end else begin
      rxTgl_q <= {rxTgl_q[1:0], sif.rxDoneTgl};
      txTgl_q <= {txTgl_q[1:0], sif.txDoneTgl};
      rxValid <= rxTgl_q[2] ^ rxTgl_q[1];
      txDone <= txTgl_q[2] ^ txTgl_q[1];
      if (rxTgl_q[2] ^ rxTgl_q[1]) begin
        rxData <= sif.rxWord;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/ssp_port_sva.sv
/* Pin assertions for ssp_port.
   Assumes bind from the bench; all checks on sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module ssp_port_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clockSourceSelect,
  input wire logic txFrameDirection,
  input wire logic portEnable,
  input wire logic floatN,
  input wire logic rxBitClock,
  input wire logic rxValid,
  input wire logic txDone,
  input wire logic rxClockLevelFlag,
  input wire logic txBitClockOut,
  input wire logic txBitClockOe,
  input wire logic txFramePulseOe,
  input wire logic serialOutOe
);
  // --------
  // checks
  // --------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence float_held; (!floatN)[*4]; endsequence
  sequence clk_wanted; (clockSourceSelect && portEnable && floatN)[*4]; endsequence
  clk_input_a: assert property ((!clockSourceSelect)[*3] |-> !txBitClockOe) else $error("clock driven");
  clk_drive_a: assert property (clk_wanted |-> txBitClockOe) else $error("clock not driven");
  clk_half_a: assert property (txBitClockOe && $past(txBitClockOe) |-> txBitClockOut != $past(txBitClockOut))
    else $error("clock not halved");
  reset_input_a: assert property ($past(!rstn) |-> !txBitClockOe && !txFramePulseOe) else $error("pin out at reset");
  frame_input_a: assert property ((!txFrameDirection)[*3] |-> !txFramePulseOe) else $error("frame driven");
  float_data_a: assert property (float_held |-> !serialOutOe && !txFramePulseOe) else $error("not floated");
  clk_float_a: assert property ((!floatN && !portEnable)[*4] |-> !txBitClockOe) else $error("clock not floated");
  flag_level_a: assert property ((!portEnable && $stable(rxBitClock))[*4] |-> rxClockLevelFlag == rxBitClock)
    else $error("flag wrong");
  rx_single_a: assert property (rxValid |=> !rxValid) else $error("rx pulse long");
  tx_single_a: assert property (txDone |=> !txDone) else $error("tx pulse long");
endmodule
`default_nettype wire

// ### sim/ssp_partner.sv
/* Far-side serial peripheral: gated bit clock, frame pulse, data.
   Assumes ssp_port samples on the rising bit clock edge. */
`timescale 1ns/10ps
`default_nettype none
module ssp_partner (
  output logic linkClk,
  output logic frameN,
  output logic serialIn,
  input wire logic serialOut
);
  logic run;
  logic idleLvl;
  logic [15:0] got;
  // -------------------------------
  // clock stands still between frames
  // -------------------------------
  initial begin
    run = 1'b1;
    idleLvl = 1'b0;
    linkClk = 1'b0;
    frameN = 1'b1;
    serialIn = 1'b0;
    #5;
    forever #32 linkClk = run ? ~linkClk : idleLvl;
  end
  // lag: bit clocks by which the device's own frame trails ours
  task automatic xfer(input logic [15:0] w, input int lag);
    run = 1'b1;
    @(negedge linkClk);
    // first bit stands with the frame fall; the port takes it at that edge
    frameN = 1'b0;
    serialIn = w[15];
    for (int i = 0; i < 20; i++) begin
      @(negedge linkClk);
      if (i == 0) frameN = 1'b1;
      // released line shows the inverse, not a stale bit
      serialIn = (i < 15) ? w[14 - i] : ~w[0];
      if (i > lag && i <= 16 + lag) got[16 + lag - i] = serialOut;
    end
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/ssp_port_bench.sv
/* Self-checking bench for ssp_port with its far-side partner.
   Assumes the partner clock feeds every bit clock input. */
`timescale 1ns/10ps
`default_nettype none
module ssp_port_bench;
  logic sys_clk, rstn, css, tfd, pe, floatN, txLoad, rxSeen, txSeen, tclk, tfs;
  logic [15:0] txData, rxData, rxGot;
  logic rxValid, txDone, flag, tbo, tbOe, tfo, tfOe, sout, soOe, lclk, frm, sin;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  ssp_partner p_u (.linkClk(lclk), .frameN(frm), .serialIn(sin), .serialOut(sout));
  ssp_port dut_u (.sys_clk(sys_clk), .rstn(rstn), .linkClk(lclk), .clockSourceSelect(css),
    .txFrameDirection(tfd), .portEnable(pe), .floatN(floatN), .txData(txData), .txLoad(txLoad),
    .txFrameStart(tfs), .rxData(rxData), .rxValid(rxValid), .txDone(txDone), .rxClockLevelFlag(flag),
    .txBitClockIn(lclk), .txBitClockOut(tbo), .txBitClockOe(tbOe), .rxBitClock(lclk), .txFramePulseIn(frm),
    .txFramePulseOut(tfo), .txFramePulseOe(tfOe), .rxFramePulse(frm), .serialIn(sin), .serialOut(sout),
    .serialOutOe(soOe));
  // ----------
  // helpers
  // ----------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rxValid === 1'b1) rxSeen <= 1'b1;
    if (rxValid === 1'b1) rxGot <= rxData;
    if (txDone === 1'b1) txSeen <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // -----------
  // scenarios
  // -----------
  task automatic t_xfer(input logic [15:0] tw, input logic [15:0] rw);
    txData <= tw;
    txLoad <= 1'b1;
    rxSeen <= 1'b0;
    txSeen <= 1'b0;
    step(1);
    txLoad <= 1'b0;
    step(30);
    p_u.xfer(rw, 0);
    for (int n = 0; n < 40 && !(rxSeen && txSeen); n++) step(1);
    check(rxGot, rw, "rx word");
    check(p_u.got, tw, "tx word");
    check({15'h0000, txSeen}, 16'h0001, "tx done");
    $display("transfer test done");
  endtask
  task automatic t_frame(input logic [15:0] tw, input logic [15:0] rw);
    tfd <= 1'b1;
    txData <= tw;
    txLoad <= 1'b1;
    rxSeen <= 1'b0;
    txSeen <= 1'b0;
    step(1);
    txLoad <= 1'b0;
    tfs <= 1'b1;
    step(1);
    tfs <= 1'b0;
    step(30);
    check({14'h0000, tfOe, tfo}, 16'h0002, "frame out low");
    // own frame passes two bit clock flops, so it trails the partner by one
    p_u.xfer(rw, 1);
    for (int n = 0; n < 40 && !(rxSeen && txSeen); n++) step(1);
    step(2);
    check(rxGot, rw, "rx word own frame");
    check(p_u.got, tw, "tx word own frame");
    check({14'h0000, txSeen, tfo}, 16'h0003, "frame out released");
    tfd <= 1'b0;
    $display("own frame test done");
  endtask
  task automatic t_pins();
    check({13'h0000, tbOe, tfOe, soOe}, 16'h0001, "reset oe");
    pe <= 1'b1;
    css <= 1'b1;
    tfd <= 1'b1;
    step(6);
    tclk = tbo;
    step(1);
    check({14'h0000, tbOe, tfOe}, 16'h0003, "oe on");
    check({15'h0000, tbo}, {15'h0000, ~tclk}, "half clock");
    pe <= 1'b0;
    floatN <= 1'b0;
    step(6);
    check({13'h0000, tbOe, tfOe, soOe}, 16'h0000, "floated");
    p_u.idleLvl = 1'b1;
    step(10);
    check({15'h0000, flag}, 16'h0001, "flag high");
    p_u.idleLvl = 1'b0;
    step(10);
    check({15'h0000, flag}, 16'h0000, "flag low");
    floatN <= 1'b1;
    css <= 1'b0;
    tfd <= 1'b0;
    pe <= 1'b1;
    step(6);
    check({15'h0000, tbOe}, 16'h0000, "clock input");
    $display("pin test done");
  endtask
  initial begin
    {rstn, css, tfd, pe, txLoad, tfs} = 6'h00;
    floatN = 1'b1;
    txData = 16'h0000;
    step(10);
    rstn <= 1'b1;
    p_u.run = 1'b0;
    step(3);
    t_pins();
    t_xfer(16'hA5C3, 16'h3C5A);
    t_xfer(16'h8001, 16'h7FFE);
    t_frame(16'hC3A5, 16'h5A3C);
    print_verdict();
  end
endmodule
bind ssp_port ssp_port_sva chk_u (.sys_clk(sys_clk), .rstn(rstn), .clockSourceSelect(clockSourceSelect),
  .txFrameDirection(txFrameDirection), .portEnable(portEnable), .floatN(floatN), .rxBitClock(rxBitClock),
  .rxValid(rxValid), .txDone(txDone), .rxClockLevelFlag(rxClockLevelFlag), .txBitClockOut(txBitClockOut),
  .txBitClockOe(txBitClockOe), .txFramePulseOe(txFramePulseOe), .serialOutOe(serialOutOe));
`default_nettype wire
